// ===== bench/esc_event_model.sv
// Stand-in for the MAC datapath that reports finished frames to the counters.
`timescale 1ns/1ps
module esc_event_model (
    input  wire logic        mclk_i,
    input  wire logic        coll_i,
    output logic             rx_done_o,
    output logic [10:0]      rx_len_o,
    output logic [4:0]       rx_flags_o,
    output logic             tx_done_o,
    output logic [5:0]       tx_flags_o
);
    initial begin
        rx_done_o = 1'b0;
        rx_len_o = 11'h000;
        rx_flags_o = 5'h00;
        tx_done_o = 1'b0;
        tx_flags_o = 6'h00;
    end

    // Flags are {whole, crc_bad, sym_err, addr_match, copied}; lines flip once released.
    task automatic rx_frame(input logic [10:0] len, input logic [4:0] f);
        @(posedge mclk_i);
        rx_done_o <= 1'b1;
        rx_len_o <= len;
        rx_flags_o <= f;
        @(posedge mclk_i);
        rx_done_o <= 1'b0;
        rx_len_o <= ~len;
        rx_flags_o <= ~f;
    endtask : rx_frame

    // Flags are {deferred, collision, late, excess, underrun, carrier}.
    task automatic tx_frame(input logic [5:0] f, output logic coll);
        @(posedge mclk_i);
        tx_done_o <= 1'b1;
        tx_flags_o <= f;
        @(posedge mclk_i);
        coll = coll_i;
        tx_done_o <= 1'b0;
        tx_flags_o <= ~f;
    endtask : tx_frame
endmodule : esc_event_model

// ===== bench/esc_stats_bench.sv
// Self-checking bench for the statistics counter block.
`timescale 1ns/1ps
`include "esc_defines.svh"
module esc_stats_bench import esc_pkg::*;;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [5:0] addr = 6'h00;
    logic rd_r = 1'b0;
    logic wr_r = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic wait_o, coll, rx_en, big, half, rx_done, tx_done, c;
    logic [10:0] rx_len;
    logic [4:0] rx_f;
    logic [5:0] tx_f;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    localparam logic [4:0] GOOD = 5'b10011, CRCB = 5'b11011, SYMW = 5'b10111;
    localparam logic [4:0] ALC = 5'b01011, ALS = 5'b00111;
    localparam logic [31:0] RX = 32'h4, WEN = 32'h80, BIG = 32'h100, HALF = 32'h200;

    always #4 mclk_i = ~mclk_i;

    esc_stats esc_stats_inst (.mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(addr),
        .avs_read_i(rd_r), .avs_write_i(wr_r), .avs_writedata_i(wdata),
        .avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
        .rx_frame_done_i(rx_done), .rx_len_i(rx_len), .rx_whole_bytes_i(rx_f[4]),
        .rx_crc_bad_i(rx_f[3]), .rx_sym_err_i(rx_f[2]), .rx_addr_match_i(rx_f[1]),
        .rx_copied_i(rx_f[0]), .tx_frame_done_i(tx_done), .tx_deferred_i(tx_f[5]),
        .tx_collision_i(tx_f[4]), .tx_late_col_i(tx_f[3]), .tx_excess_col_i(tx_f[2]),
        .tx_underrun_i(tx_f[1]), .tx_carrier_err_i(tx_f[0]), .coll_stat_inc_o(coll),
        .rx_enable_o(rx_en), .big_frames_o(big), .half_duplex_o(half));

    esc_event_model esc_event_model_inst (.mclk_i(mclk_i), .coll_i(coll),
        .rx_done_o(rx_done), .rx_len_o(rx_len), .rx_flags_o(rx_f),
        .tx_done_o(tx_done), .tx_flags_o(tx_f));

    task automatic check(input esc_word_t seen, input esc_word_t exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Bus cycle: hold the request until waitrequest is sampled low at an edge.
    task automatic bus(input logic [5:0] a, input logic w, input esc_word_t d,
                       output esc_word_t q);
        logic w_s;
        @(posedge mclk_i);
        addr <= a;
        wdata <= d;
        rd_r <= ~w;
        wr_r <= w;
        // Waitrequest is read where it has settled, ahead of the edge that ends the cycle.
        do begin
            @(negedge mclk_i);
            w_s = wait_o;
            @(posedge mclk_i);
        end while (w_s !== 1'b0);
        q = rdata;
        rd_r <= 1'b0;
        wr_r <= 1'b0;
    endtask : bus

    task automatic wr(input logic [5:0] a, input esc_word_t d);
        esc_word_t q;
        bus(a, 1'b1, d, q);
    endtask : wr

    task automatic rchk(input logic [5:0] a, input esc_word_t exp);
        esc_word_t q;
        bus(a, 1'b0, 32'h0, q);
        check(q, exp);
    endtask : rchk

    task automatic rx(input logic [10:0] len, input logic [4:0] f);
        esc_event_model_inst.rx_frame(len, f);
    endtask : rx

    task automatic tx(input logic [5:0] f, input logic exp_coll);
        esc_event_model_inst.tx_frame(f, c);
        check({31'h0, c}, {31'h0, exp_coll});
    endtask : tx

    task automatic t_reset();
        for (int i = 0; i < 8; i++) rchk(6'(i * 4), 32'h0);
        rchk(`ESC_OFF_CTRL, 32'h0);
        rchk(6'h24, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_good();
        wr(`ESC_OFF_CTRL, RX);
        rx(11'd64, GOOD);
        rx(11'd1518, GOOD);
        rx(11'd1519, GOOD);
        rx(11'd63, GOOD);
        rx(11'd1536, GOOD);
        rx(11'd100, 5'b10001);
        rx(11'd100, 5'b10010);
        rx(11'd100, 5'b00011);
        wr(`ESC_OFF_CTRL, RX | BIG);
        check({29'h0, rx_en, big, half}, 32'h6);
        rx(11'd1536, GOOD);
        rx(11'd1537, GOOD);
        rchk(`ESC_OFF_GOOD_RX, 32'h3);
        rchk(`ESC_OFF_GOOD_RX, 32'h0);
        $display("test good frames done");
    endtask : t_good

    task automatic t_errors();
        wr(`ESC_OFF_CTRL, RX);
        rx(11'd64, CRCB);
        rx(11'd1518, SYMW);
        rx(11'd1519, CRCB);
        rx(11'd100, ALC);
        rx(11'd100, ALS);
        rx(11'd63, ALC);
        rchk(`ESC_OFF_CRC_ERR, 32'h2);
        rchk(`ESC_OFF_ALIGN_ERR, 32'h2);
        rchk(`ESC_OFF_GOOD_RX, 32'h0);
        wr(`ESC_OFF_CTRL, 32'h0);
        rx(11'd100, GOOD);
        rx(11'd100, CRCB);
        rchk(`ESC_OFF_GOOD_RX, 32'h0);
        rchk(`ESC_OFF_CRC_ERR, 32'h0);
        $display("test receive errors done");
    endtask : t_errors

    task automatic t_tx();
        tx(6'b100000, 1'b0);
        tx(6'b110000, 1'b1);
        tx(6'b100010, 1'b0);
        tx(6'b001000, 1'b1);
        tx(6'b001010, 1'b0);
        tx(6'b000100, 1'b0);
        tx(6'b000001, 1'b0);
        rchk(`ESC_OFF_DEFER_TX, 32'h1);
        rchk(`ESC_OFF_LATE_COL, 32'h1);
        rchk(`ESC_OFF_TX_UNDER, 32'h2);
        rchk(`ESC_OFF_CARRIER, 32'h0);
        wr(`ESC_OFF_CTRL, HALF);
        tx(6'b000001, 1'b0);
        rchk(`ESC_OFF_CARRIER, 32'h1);
        rchk(`ESC_OFF_EXCESS_COL, 32'h1);
        $display("test transmit done");
    endtask : t_tx

    task automatic t_write();
        wr(`ESC_OFF_CTRL, 32'h0);
        wr(`ESC_OFF_GOOD_RX, 32'h123);
        rchk(`ESC_OFF_GOOD_RX, 32'h0);
        wr(`ESC_OFF_CTRL, 32'hffffffff);
        rchk(`ESC_OFF_CTRL, 32'h384);
        wr(`ESC_OFF_GOOD_RX, 32'hffffffff);
        rchk(`ESC_OFF_GOOD_RX, 32'h00ffffff);
        wr(`ESC_OFF_DEFER_TX, 32'hffffffff);
        rchk(`ESC_OFF_DEFER_TX, 32'h0000ffff);
        wr(`ESC_OFF_CRC_ERR, 32'hfe);
        rx(11'd64, CRCB);
        rx(11'd64, CRCB);
        rchk(`ESC_OFF_CRC_ERR, 32'hff);
        wr(6'h24, 32'h5);
        rchk(6'h24, 32'h0);
        $display("test writes and saturation done");
    endtask : t_write

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end

    initial begin
        repeat (4) @(posedge mclk_i);
        rst_i <= 1'b0;
        t_reset();
        t_good();
        t_errors();
        t_tx();
        t_write();
        final_report();
    end
endmodule : esc_stats_bench

// ===== logic/esc_counter.sv
// Saturating statistics counter with clear and load.
`timescale 1ns/1ps
module esc_counter #(
    parameter int W = 8
) (
    input  wire logic         mclk_i,
    input  wire logic         rst_i,
    input  wire logic         inc_i,
    input  wire logic         clr_i,
    input  wire logic         wr_i,
    input  wire logic [W-1:0] wdata_i,
    output logic      [W-1:0] cnt_o
);

    logic [W-1:0] cnt_r;

    // A load wins over a clear and an event, reset over a load; an event in the clear cycle is kept.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cnt_r <= '0;
        end else if (wr_i) begin
            cnt_r <= wdata_i;
        end else if (clr_i) begin
            cnt_r <= {{(W-1){1'b0}}, inc_i};
        end else if (inc_i && (cnt_r != {W{1'b1}})) begin
            cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign cnt_o = cnt_r;

    AST_CNT_SAT: assert property (@(posedge mclk_i) disable iff (rst_i)
        (cnt_r == {W{1'b1}}) && inc_i && !clr_i && !wr_i |=> cnt_r == {W{1'b1}})
        else $error("Counter wrapped past all ones.");

    AST_CNT_STEP: assert property (@(posedge mclk_i) disable iff (rst_i)
        (cnt_r != {W{1'b1}}) && inc_i && !clr_i && !wr_i
            |=> cnt_r == $past(cnt_r) + {{(W-1){1'b0}}, 1'b1})
        else $error("Counter did not step by one on an event.");

endmodule : esc_counter

// ===== logic/esc_defines.svh
// Register offsets, field positions, widths and reset values of the statistics block.
`ifndef ESC_DEFINES_SVH
`define ESC_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ESC_OFF_GOOD_RX    6'h00
`define ESC_OFF_CRC_ERR    6'h04
`define ESC_OFF_ALIGN_ERR  6'h08
`define ESC_OFF_DEFER_TX   6'h0c
`define ESC_OFF_LATE_COL   6'h10
`define ESC_OFF_EXCESS_COL 6'h14
`define ESC_OFF_TX_UNDER   6'h18
`define ESC_OFF_CARRIER    6'h1c
`define ESC_OFF_CTRL       6'h20

// ----------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------
`define ESC_CTRL_RX_EN_BIT   2
`define ESC_CTRL_WR_EN_BIT   7
`define ESC_CTRL_BIG_BIT     8
`define ESC_CTRL_HALF_BIT    9
`define ESC_CTRL_MASK        32'h0000_0384
`define ESC_CTRL_RESET       32'h0000_0000

// ----------------------------------------------------------------
// Counter widths and frame length limits in bytes
// ----------------------------------------------------------------
`define ESC_W_GOOD_RX    24
`define ESC_W_DEFER_TX   16
`define ESC_W_BYTE_CNT   8
`define ESC_LEN_MIN      11'd64
`define ESC_LEN_MAX      11'd1518
`define ESC_LEN_MAX_BIG  11'd1536

`endif

// ===== logic/esc_pkg.sv
// Types shared by the statistics counter block.
package esc_pkg;

    // Counter index, equal to the register word position.
    typedef enum logic [2:0] {
        ESC_GOOD_RX    = 3'b000,
        ESC_CRC_ERR    = 3'b001,
        ESC_ALIGN_ERR  = 3'b010,
        ESC_DEFER_TX   = 3'b011,
        ESC_LATE_COL   = 3'b100,
        ESC_EXCESS_COL = 3'b101,
        ESC_TX_UNDER   = 3'b110,
        ESC_CARRIER    = 3'b111
    } esc_cnt_e;

    typedef logic [31:0] esc_word_t;

endpackage : esc_pkg

// ===== logic/esc_rx_classify.sv
// Sorts a finished received frame into good, CRC error or alignment error.
`timescale 1ns/1ps
`include "esc_defines.svh"
module esc_rx_classify (
    input  wire logic [10:0] len_i,
    input  wire logic        whole_i,
    input  wire logic        crc_bad_i,
    input  wire logic        sym_err_i,
    input  wire logic        big_i,
    output logic             good_o,
    output logic             crc_err_o,
    output logic             align_err_o
);

    logic [10:0] max_len;
    logic        len_ok;
    logic        bad;

    assign max_len     = big_i ? `ESC_LEN_MAX_BIG : `ESC_LEN_MAX;
    assign len_ok      = (len_i >= `ESC_LEN_MIN) && (len_i <= max_len);
    assign bad         = crc_bad_i || sym_err_i;
    assign good_o      = len_ok && whole_i && !bad;
    assign crc_err_o   = len_ok && whole_i && bad;
    assign align_err_o = len_ok && !whole_i && bad;

endmodule : esc_rx_classify

// ===== logic/esc_stats.sv
// Ethernet MAC frame statistics counters behind an Avalon-MM slave.
// ----------------------------------------------------------------
// How it works
// - 24-bit good frame count, only address matched frames copied to memory.
// - Good means length 64 to 1518, or 1536 when big, no errors.
// - 8-bit CRC error count for whole-byte frames of valid length.
// - A symbol error on a valid whole-byte frame also counts as CRC error.
// - 8-bit alignment error count for valid odd-bit frames with bad CRC.
// - A symbol error on a valid odd-bit frame also counts as alignment error.
// - 16-bit count of frames deferred by carrier on their first attempt.
// - Deferred count skips frames with a collision, a late collision or an underrun.
// - 8-bit count of collisions seen after the 512 bit slot time.
// - A late collision also goes to the ordinary collision statistics.
// - 8-bit count of frames dropped after 16 collisions.
// - 8-bit count of frames lost to a transmit DMA underrun.
// - An underrun frame bumps no other counter.
// - Counters clear on read and stick at all ones.
// - Software writes to counters land only while write enable is set.
// - Receive counters move only while receive enable is set.
// - Half duplex only: 8-bit carrier loss count, touching nothing else.
// ----------------------------------------------------------------
`timescale 1ns/1ps
`include "esc_defines.svh"
module esc_stats
    import esc_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    // Avalon-MM slave.
    input  wire logic [5:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Receive frame report, one pulse per finished frame.
    input  wire logic        rx_frame_done_i,
    input  wire logic [10:0] rx_len_i,
    input  wire logic        rx_whole_bytes_i,
    input  wire logic        rx_crc_bad_i,
    input  wire logic        rx_sym_err_i,
    input  wire logic        rx_addr_match_i,
    input  wire logic        rx_copied_i,
    // Transmit frame report, one pulse per finished frame.
    input  wire logic        tx_frame_done_i,
    input  wire logic        tx_deferred_i,
    input  wire logic        tx_collision_i,
    input  wire logic        tx_late_col_i,
    input  wire logic        tx_excess_col_i,
    input  wire logic        tx_underrun_i,
    input  wire logic        tx_carrier_err_i,
    // Pulse to the ordinary collision statistics.
    output logic             coll_stat_inc_o,
    // Control bits for the rest of the MAC.
    output logic             rx_enable_o,
    output logic             big_frames_o,
    output logic             half_duplex_o
);

    localparam int NCNT = 8;

    // Width of each counter, by register word position.
    function automatic int cnt_width(input int idx);
        case (idx)
            0:       cnt_width = `ESC_W_GOOD_RX;
            3:       cnt_width = `ESC_W_DEFER_TX;
            default: cnt_width = `ESC_W_BYTE_CNT;
        endcase
    endfunction : cnt_width

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    esc_word_t ctrl_r;
    logic      rx_en;
    logic      stats_we;
    logic      big_frames;
    logic      half_duplex;

    assign rx_en       = ctrl_r[`ESC_CTRL_RX_EN_BIT];
    assign stats_we    = ctrl_r[`ESC_CTRL_WR_EN_BIT];
    assign big_frames  = ctrl_r[`ESC_CTRL_BIG_BIT];
    assign half_duplex = ctrl_r[`ESC_CTRL_HALF_BIT];

    assign rx_enable_o   = rx_en;
    assign big_frames_o  = big_frames;
    assign half_duplex_o = half_duplex;

    // ----------------------------------------------------------------
    // Bus handshake
    // ----------------------------------------------------------------
    // Each access takes one wait state: the request is acted on at the
    // first edge, and waitrequest drops in the cycle after it.
    logic      ack_r;
    logic      take;
    logic      rd_take;
    logic      wr_take;
    logic      cnt_hit;
    logic      ctrl_hit;
    logic [2:0] sel;

    assign take     = (avs_read_i || avs_write_i) && !ack_r;
    assign rd_take  = take && avs_read_i;
    assign wr_take  = take && avs_write_i;
    assign cnt_hit  = (avs_address_i[5] == 1'b0) && (avs_address_i[1:0] == 2'b00);
    assign ctrl_hit = (avs_address_i == `ESC_OFF_CTRL);
    assign sel      = avs_address_i[4:2];

    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= take;
        end
    end

    // ----------------------------------------------------------------
    // Byte lane merge for writes
    // ----------------------------------------------------------------
    logic [31:0] cnt32 [NCNT];
    esc_word_t   cur_word;
    esc_word_t   wmerge;

    assign cur_word = ctrl_hit ? ctrl_r : cnt32[sel];

    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++) begin : g_lane
            assign wmerge[gb*8 +: 8] = avs_byteenable_i[gb] ?
                                       avs_writedata_i[gb*8 +: 8] :
                                       cur_word[gb*8 +: 8];
        end
    endgenerate

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ctrl_r <= `ESC_CTRL_RESET;
        end else if (wr_take && ctrl_hit) begin
            ctrl_r <= wmerge & `ESC_CTRL_MASK;
        end
    end

    // ----------------------------------------------------------------
    // Receive event decode
    // ----------------------------------------------------------------
    logic rx_good;
    logic rx_crc_err;
    logic rx_align_err;

    esc_rx_classify u_classify (
        .len_i       (rx_len_i),
        .whole_i     (rx_whole_bytes_i),
        .crc_bad_i   (rx_crc_bad_i),
        .sym_err_i   (rx_sym_err_i),
        .big_i       (big_frames),
        .good_o      (rx_good),
        .crc_err_o   (rx_crc_err),
        .align_err_o (rx_align_err)
    );

    logic rx_ev;

    assign rx_ev = rx_frame_done_i && rx_en;

    // ----------------------------------------------------------------
    // Transmit event decode
    // ----------------------------------------------------------------
    logic tx_ev;
    logic tx_ok;

    assign tx_ev = tx_frame_done_i;
    assign tx_ok = tx_ev && !tx_underrun_i;

    // ----------------------------------------------------------------
    // Counter increments
    // ----------------------------------------------------------------
    logic [NCNT-1:0] inc;

    always_comb begin
        inc = '0;
        inc[ESC_GOOD_RX]    = rx_ev && rx_good && rx_addr_match_i && rx_copied_i;
        inc[ESC_CRC_ERR]    = rx_ev && rx_crc_err;
        inc[ESC_ALIGN_ERR]  = rx_ev && rx_align_err;
        inc[ESC_DEFER_TX]   = tx_ok && tx_deferred_i
                              && !tx_collision_i && !tx_late_col_i;
        inc[ESC_LATE_COL]   = tx_ok && tx_late_col_i;
        inc[ESC_EXCESS_COL] = tx_ok && tx_excess_col_i;
        inc[ESC_TX_UNDER]   = tx_ev && tx_underrun_i;
        inc[ESC_CARRIER]    = tx_ok && half_duplex && tx_carrier_err_i
                              && !tx_collision_i && !tx_late_col_i;
    end

    // A late collision is also a collision for the collision counters.
    assign coll_stat_inc_o = tx_ok && (tx_collision_i || tx_late_col_i);

    // ----------------------------------------------------------------
    // Counter bank
    // ----------------------------------------------------------------
    genvar gc;
    generate
        for (gc = 0; gc < NCNT; gc++) begin : g_cnt
            localparam int W = cnt_width(gc);
            logic [W-1:0] val;
            logic         hit;

            assign hit = cnt_hit && (sel == 3'(gc));

            esc_counter #(
                .W (W)
            ) u_cnt (
                .mclk_i  (mclk_i),
                .rst_i   (rst_i),
                .inc_i   (inc[gc]),
                .clr_i   (rd_take && hit),
                .wr_i    (wr_take && hit && stats_we),
                .wdata_i (wmerge[W-1:0]),
                .cnt_o   (val)
            );

            if (W < 32) begin : g_pad
                assign cnt32[gc] = {{(32-W){1'b0}}, val};
            end else begin : g_full
                assign cnt32[gc] = val;
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    // The value is captured at the same edge that clears the counter,
    // so no event is lost between the snapshot and the clear.
    esc_word_t rdata_r;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rdata_r <= '0;
        end else if (rd_take) begin
            if (ctrl_hit) begin
                rdata_r <= ctrl_r;
            end else if (cnt_hit) begin
                rdata_r <= cnt32[sel];
            end else begin
                rdata_r <= '0;
            end
        end
    end

    assign avs_readdata_o = rdata_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_req_taken;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence

    sequence s_req_done;
        !avs_waitrequest_o;
    endsequence

    AST_BUS_ONE_WAIT: assert property (@(posedge mclk_i) disable iff (rst_i)
        s_req_taken |=> s_req_done)
        else $error("Bus answer did not come one cycle after the request.");

    AST_CLEAR_ON_READ: assert property (@(posedge mclk_i) disable iff (rst_i)
        rd_take && cnt_hit && (sel == 3'b001) && !inc[ESC_CRC_ERR]
            |=> cnt32[1] == 32'h0000_0000)
        else $error("Counter not cleared by a read.");

    AST_READ_VALUE: assert property (@(posedge mclk_i) disable iff (rst_i)
        rd_take && cnt_hit |=> avs_readdata_o == $past(cnt32[sel]))
        else $error("Read data differ from the counter before clearing.");

    AST_WRITE_LOCKED: assert property (@(posedge mclk_i) disable iff (rst_i)
        wr_take && cnt_hit && (sel == 3'b000) && !stats_we && !inc[ESC_GOOD_RX]
            |=> cnt32[0] == $past(cnt32[0]))
        else $error("Counter changed by a write while writes are locked.");

    AST_WRITE_LANDS: assert property (@(posedge mclk_i) disable iff (rst_i)
        wr_take && cnt_hit && (sel == 3'b100) && stats_we
            |=> cnt32[4][7:0] == $past(wmerge[7:0]))
        else $error("Enabled write did not load the counter.");

    AST_UPPER_ZERO: assert property (@(posedge mclk_i) disable iff (rst_i)
        rd_take && cnt_hit && (sel != 3'b000) && (sel != 3'b011)
            |=> avs_readdata_o[31:8] == 24'h00_0000)
        else $error("Bits above an 8-bit counter read non-zero.");

    AST_RX_GATED: assert property (@(posedge mclk_i) disable iff (rst_i)
        !rx_en |-> inc[2:0] == 3'b000)
        else $error("Receive counter moved with receive disabled.");

    AST_GOOD_LEN: assert property (@(posedge mclk_i) disable iff (rst_i)
        inc[ESC_GOOD_RX] |-> (rx_len_i >= `ESC_LEN_MIN) && !rx_crc_bad_i
            && !rx_sym_err_i && (rx_len_i <= (big_frames ? `ESC_LEN_MAX_BIG
                                                         : `ESC_LEN_MAX)))
        else $error("Good frame counted outside length or with errors.");

    AST_GOOD_COPIED: assert property (@(posedge mclk_i) disable iff (rst_i)
        inc[ESC_GOOD_RX] |-> rx_addr_match_i && rx_copied_i)
        else $error("Good frame counted without match and copy.");

    AST_CRC_WHOLE: assert property (@(posedge mclk_i) disable iff (rst_i)
        inc[ESC_CRC_ERR] |-> rx_whole_bytes_i && !inc[ESC_ALIGN_ERR])
        else $error("CRC error counted on an odd-bit frame.");

    AST_ALIGN_ODD: assert property (@(posedge mclk_i) disable iff (rst_i)
        inc[ESC_ALIGN_ERR] |-> !rx_whole_bytes_i && (rx_crc_bad_i || rx_sym_err_i))
        else $error("Alignment error counted on a whole-byte or clean frame.");

    AST_SYM_COUNTS: assert property (@(posedge mclk_i) disable iff (rst_i)
        rx_ev && rx_sym_err_i && rx_whole_bytes_i && (rx_len_i >= `ESC_LEN_MIN)
            && (rx_len_i <= `ESC_LEN_MAX) |-> inc[ESC_CRC_ERR])
        else $error("Symbol error on a valid frame not counted.");

    AST_DEFER_CLEAN: assert property (@(posedge mclk_i) disable iff (rst_i)
        inc[ESC_DEFER_TX] |-> !tx_collision_i && !tx_underrun_i)
        else $error("Deferred frame counted despite collision or underrun.");

    AST_UNDER_ALONE: assert property (@(posedge mclk_i) disable iff (rst_i)
        tx_ev && tx_underrun_i |-> inc[7:3] == 5'b01000 && !coll_stat_inc_o)
        else $error("Underrun frame bumped another counter.");

    AST_LATE_TWICE: assert property (@(posedge mclk_i) disable iff (rst_i)
        inc[ESC_LATE_COL] |-> coll_stat_inc_o)
        else $error("Late collision not passed to collision statistics.");

    AST_EXCESS: assert property (@(posedge mclk_i) disable iff (rst_i)
        tx_ok && tx_excess_col_i |-> inc[ESC_EXCESS_COL])
        else $error("Excess collision frame not counted.");

    AST_CARRIER_HALF: assert property (@(posedge mclk_i) disable iff (rst_i)
        inc[ESC_CARRIER] |-> half_duplex && !tx_collision_i)
        else $error("Carrier loss counted outside half duplex.");

endmodule : esc_stats
